// File: src/dpmb_mailbox.sv
// dual-port mailbox bypass: two mail registers with flags between port a and port b
`timescale 1ns/10ps
`include "dpmb_consts.svh"
module dpmb_mailbox
(
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    port_a_chip_select_n_in,
    input  wire logic                    port_a_write_not_read_in,
    input  wire logic                    port_a_enable_in,
    input  wire logic                    port_a_box_select_in,
    input  wire dpmb_pkg::dpmb_word_t    port_a_data_bus_in,
    output logic [`DPMB_DATA_W-1:0]      port_a_data_bus_out,
    output logic                         port_a_data_bus_oe_out,
    input  wire logic                    port_b_chip_select_n_in,
    input  wire logic                    port_b_write_not_read_in,
    input  wire logic                    port_b_enable_in,
    input  wire logic                    port_b_box_select_in,
    input  wire dpmb_pkg::dpmb_word_t    port_b_data_bus_in,
    input  wire dpmb_pkg::dpmb_word_t    fifo_out_word_in,
    output logic [`DPMB_DATA_W-1:0]      port_b_data_bus_out,
    output logic                         port_b_data_bus_oe_out,
    output logic                         port_a_fifo_write_out,
    output logic                         port_b_fifo_read_out,
    output logic                         a_to_b_mail_flag_n_out,
    output logic                         b_to_a_mail_flag_n_out
);

    // ----------------------------------------------------------------
    // input synchronisers (pins arrive from outside the clock domain)
    // ----------------------------------------------------------------
    localparam int CW = `DPMB_CTL_W;
    logic [CW-1:0]       ctl_a_s1_q;
    logic [CW-1:0]       ctl_a_s2_q;
    logic [CW-1:0]       ctl_b_s1_q;
    logic [CW-1:0]       ctl_b_s2_q;
    dpmb_pkg::dpmb_word_t data_a_s1_q;
    dpmb_pkg::dpmb_word_t data_a_s2_q;
    dpmb_pkg::dpmb_word_t data_b_s1_q;
    dpmb_pkg::dpmb_word_t data_b_s2_q;
    wire [CW-1:0] ctl_a_raw = {port_a_chip_select_n_in, port_a_write_not_read_in,
                               port_a_enable_in, port_a_box_select_in};
    wire [CW-1:0] ctl_b_raw = {port_b_chip_select_n_in, port_b_write_not_read_in,
                               port_b_enable_in, port_b_box_select_in};

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctl_a_s1_q  <= `DPMB_CTL_A_RST;
            ctl_a_s2_q  <= `DPMB_CTL_A_RST;
            ctl_b_s1_q  <= `DPMB_CTL_B_RST;
            ctl_b_s2_q  <= `DPMB_CTL_B_RST;
            data_a_s1_q <= `DPMB_DATA_RST;
            data_a_s2_q <= `DPMB_DATA_RST;
            data_b_s1_q <= `DPMB_DATA_RST;
            data_b_s2_q <= `DPMB_DATA_RST;
        end
        else
        begin
            ctl_a_s1_q  <= ctl_a_raw;
            ctl_a_s2_q  <= ctl_a_s1_q;
            ctl_b_s1_q  <= ctl_b_raw;
            ctl_b_s2_q  <= ctl_b_s1_q;
            data_a_s1_q <= port_a_data_bus_in;
            data_a_s2_q <= data_a_s1_q;
            data_b_s1_q <= port_b_data_bus_in;
            data_b_s2_q <= data_b_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // port decode
    // ----------------------------------------------------------------
    dpmb_pkg::dpmb_ctl_t ca;
    dpmb_pkg::dpmb_ctl_t cb;
    // port a: write is direction high, read is direction low
    assign ca.sel = ~ctl_a_s2_q[`DPMB_CTL_CS_N];
    assign ca.wr  = ca.sel & ctl_a_s2_q[`DPMB_CTL_DIR];
    assign ca.rd  = ca.sel & ~ctl_a_s2_q[`DPMB_CTL_DIR];
    assign ca.en  = ctl_a_s2_q[`DPMB_CTL_EN];
    assign ca.box = ctl_a_s2_q[`DPMB_CTL_BOX];
    // port b: read is direction high, write is direction low
    assign cb.sel = ~ctl_b_s2_q[`DPMB_CTL_CS_N];
    assign cb.wr  = cb.sel & ~ctl_b_s2_q[`DPMB_CTL_DIR];
    assign cb.rd  = cb.sel & ctl_b_s2_q[`DPMB_CTL_DIR];
    assign cb.en  = ctl_b_s2_q[`DPMB_CTL_EN];
    assign cb.box = ctl_b_s2_q[`DPMB_CTL_BOX];
    // every strobe below needs enable, so a cycle with enable low changes no mail register, flag or fifo strobe

    wire a_mail_wr = ca.wr & ca.en & ca.box;
    wire a_mail_rd = ca.rd & ca.en & ca.box;
    wire b_mail_wr = cb.wr & cb.en & cb.box;
    wire b_mail_rd = cb.rd & cb.en & cb.box;

    // fifo path when box select low
    assign port_a_fifo_write_out = ca.wr & ca.en & ~ca.box;
    assign port_b_fifo_read_out  = cb.rd & cb.en & ~cb.box;

    // ----------------------------------------------------------------
    // mail registers and flags
    // ----------------------------------------------------------------
    // reset empties both boxes: no mail is pending after power-up
    dpmb_pkg::dpmb_word_t a_to_b_mail_reg_q;
    dpmb_pkg::dpmb_word_t b_to_a_mail_reg_q;
    logic                 a2b_flag_n_q;
    logic                 b2a_flag_n_q;

    wire a2b_accept = a_mail_wr & a2b_flag_n_q;
    wire b2a_accept = b_mail_wr & b2a_flag_n_q;

    // write clears from writer, read sets from reader; an accepted write wins
    wire a2b_flag_n_d = a2b_accept ? 1'b0 : (b_mail_rd ? 1'b1 : a2b_flag_n_q);
    wire b2a_flag_n_d = b2a_accept ? 1'b0 : (a_mail_rd ? 1'b1 : b2a_flag_n_q);

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            a_to_b_mail_reg_q <= `DPMB_DATA_RST;
            b_to_a_mail_reg_q <= `DPMB_DATA_RST;
            a2b_flag_n_q   <= `DPMB_FLAG_RST;
            b2a_flag_n_q   <= `DPMB_FLAG_RST;
        end
        else
        begin
            if (a2b_accept)
                a_to_b_mail_reg_q <= data_a_s2_q;
            if (b2a_accept)
                b_to_a_mail_reg_q <= data_b_s2_q;
            a2b_flag_n_q <= a2b_flag_n_d;
            b2a_flag_n_q <= b2a_flag_n_d;
        end
    end

    assign a_to_b_mail_flag_n_out = a2b_flag_n_q;
    assign b_to_a_mail_flag_n_out = b2a_flag_n_q;

    // ----------------------------------------------------------------
    // output drive
    // ----------------------------------------------------------------
    // a selected read decides who drives; the three-state buffers sit at the pins
    wire a_drive = ca.rd;
    wire b_drive = cb.rd;

    assign port_a_data_bus_oe_out = a_drive;
    assign port_a_data_bus_out    = b_to_a_mail_reg_q;
    assign port_b_data_bus_oe_out = b_drive;
    assign port_b_data_bus_out    = cb.box ? a_to_b_mail_reg_q : fifo_out_word_in;

    // ----------------------------------------------------------------
    // assertions: write side, capture and refusal while full
    // ----------------------------------------------------------------
    AST_A2B_WRITE_CLEARS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        a2b_accept |=> !a_to_b_mail_flag_n_out)
        else $error("a-to-b flag not low after write");
    AST_B2A_WRITE_CLEARS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        b2a_accept |=> !b_to_a_mail_flag_n_out)
        else $error("b-to-a flag not low after write");
    AST_A2B_CAPTURE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        a2b_accept |=> a_to_b_mail_reg_q == $past(data_a_s2_q))
        else $error("a-to-b word not captured");
    AST_B2A_CAPTURE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        b2a_accept |=> b_to_a_mail_reg_q == $past(data_b_s2_q))
        else $error("b-to-a word not captured");
    // the stored word must be the pin word of three edges back, synchronisers included
    AST_A2B_PIN_TO_REG: assert property (
        @(posedge clk_in) disable iff (rst_in)
        a2b_accept |=> a_to_b_mail_reg_q == $past(port_a_data_bus_in, `DPMB_PIN_TO_REG))
        else $error("a-to-b word differs from port-a bus");
    AST_B2A_PIN_TO_REG: assert property (
        @(posedge clk_in) disable iff (rst_in)
        b2a_accept |=> b_to_a_mail_reg_q == $past(port_b_data_bus_in, `DPMB_PIN_TO_REG))
        else $error("b-to-a word differs from port-b bus");
    AST_A2B_HOLD_FULL: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !a_to_b_mail_flag_n_out |=> $stable(a_to_b_mail_reg_q))
        else $error("a-to-b overwritten while full");
    AST_B2A_HOLD_FULL: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !b_to_a_mail_flag_n_out |=> $stable(b_to_a_mail_reg_q))
        else $error("b-to-a overwritten while full");
    AST_A2B_HOLD_READ: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !a_mail_wr |=> $stable(a_to_b_mail_reg_q))
        else $error("a-to-b changed without write");
    AST_B2A_HOLD_READ: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !b_mail_wr |=> $stable(b_to_a_mail_reg_q))
        else $error("b-to-a changed without write");

    // ----------------------------------------------------------------
    // assertions: read side and flag ownership
    // ----------------------------------------------------------------
    AST_A2B_READ_SETS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (b_mail_rd && !a2b_accept) |=> a_to_b_mail_flag_n_out)
        else $error("a-to-b flag not set by port-b read");
    AST_B2A_READ_SETS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (a_mail_rd && !b2a_accept) |=> b_to_a_mail_flag_n_out)
        else $error("b-to-a flag not set by port-a read");
    AST_NO_EN_NO_FLAG: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!ca.en && !cb.en) |=> $stable(a_to_b_mail_flag_n_out))
        else $error("flag moved without enable");
    AST_NO_EN_NO_FLAG_BA: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!ca.en && !cb.en) |=> $stable(b_to_a_mail_flag_n_out))
        else $error("b-to-a flag moved without enable");
    // a flag edge must trace back to a strobe of the port that owns that edge
    AST_A2B_CLR_OWNER: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $fell(a_to_b_mail_flag_n_out) |-> $past(a_mail_wr))
        else $error("a-to-b flag cleared without port-a write");
    AST_A2B_SET_OWNER: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(a_to_b_mail_flag_n_out) |-> $past(b_mail_rd))
        else $error("a-to-b flag set without port-b read");
    AST_B2A_CLR_OWNER: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $fell(b_to_a_mail_flag_n_out) |-> $past(b_mail_wr))
        else $error("b-to-a flag cleared without port-b write");
    AST_B2A_SET_OWNER: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(b_to_a_mail_flag_n_out) |-> $past(a_mail_rd))
        else $error("b-to-a flag set without port-a read");

    // ----------------------------------------------------------------
    // assertions: output drive
    // ----------------------------------------------------------------
    // depths follow the two synchroniser stages, so the pins are the reference
    AST_A_DRIVE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        port_a_data_bus_oe_out ==
            $past(!port_a_chip_select_n_in && !port_a_write_not_read_in, `DPMB_SYNC_STAGES))
        else $error("port a drive differs from selected read");
    AST_B_DRIVE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        port_b_data_bus_oe_out ==
            $past(!port_b_chip_select_n_in && port_b_write_not_read_in, `DPMB_SYNC_STAGES))
        else $error("port b drive differs from selected read");
    AST_A_SHOWS_MAIL: assert property (
        @(posedge clk_in) disable iff (rst_in)
        port_a_data_bus_oe_out |-> port_a_data_bus_out == b_to_a_mail_reg_q)
        else $error("port a not showing b-to-a mail");
    AST_B_SELECT: assert property (
        @(posedge clk_in) disable iff (rst_in)
        port_b_data_bus_out ==
            ($past(port_b_box_select_in, `DPMB_SYNC_STAGES) ? a_to_b_mail_reg_q : fifo_out_word_in))
        else $error("port b source differs from box select");

    // ----------------------------------------------------------------
    // assertions: fifo path
    // ----------------------------------------------------------------
    AST_A_FIFO_WR: assert property (
        @(posedge clk_in) disable iff (rst_in)
        port_a_fifo_write_out == $past(!port_a_chip_select_n_in && port_a_write_not_read_in &&
            port_a_enable_in && !port_a_box_select_in, `DPMB_SYNC_STAGES))
        else $error("port a fifo write strobe wrong");
    AST_B_FIFO_RD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        port_b_fifo_read_out == $past(!port_b_chip_select_n_in && port_b_write_not_read_in &&
            port_b_enable_in && !port_b_box_select_in, `DPMB_SYNC_STAGES))
        else $error("port b fifo read strobe wrong");

    // ----------------------------------------------------------------
    // scenario covers
    // ----------------------------------------------------------------
    // each one marks a path that the bench is meant to exercise
    COV_A2B_ROUND: cover property (
        @(posedge clk_in) disable iff (rst_in)
        a2b_accept ##[1:20] b_mail_rd);
    COV_B2A_ROUND: cover property (
        @(posedge clk_in) disable iff (rst_in)
        b2a_accept ##[1:20] a_mail_rd);
    COV_BLOCKED: cover property (
        @(posedge clk_in) disable iff (rst_in)
        a_mail_wr && !a2b_flag_n_q);
    COV_B_FIFO_READ: cover property (
        @(posedge clk_in) disable iff (rst_in)
        port_b_fifo_read_out ##1 port_b_fifo_read_out);
    COV_ENABLE_LOW_WRITE: cover property (
        @(posedge clk_in) disable iff (rst_in)
        ca.wr && ca.box && !ca.en);

endmodule : dpmb_mailbox

// File: src/dpmb_consts.svh
// constants for the dual-port mailbox bypass block
`ifndef DPMB_CONSTS_SVH
`define DPMB_CONSTS_SVH

`define DPMB_DATA_W      36
`define DPMB_DATA_RST    36'h000000000
`define DPMB_FLAG_RST    1'b1

// control nibble bit positions: chip select (active low), direction, enable, box select
`define DPMB_CTL_W       4
`define DPMB_CTL_CS_N    3
`define DPMB_CTL_DIR     2
`define DPMB_CTL_EN      1
`define DPMB_CTL_BOX     0

// idle levels loaded into the control synchronisers by reset
`define DPMB_CTL_A_RST   4'hC
`define DPMB_CTL_B_RST   4'h8

// edges from a pin to its decoded strobe, and from a pin to the stored word
`define DPMB_SYNC_STAGES 2
`define DPMB_PIN_TO_REG  3

`endif

// File: src/dpmb_pkg.sv
// types for the dual-port mailbox bypass block
`include "dpmb_consts.svh"
package dpmb_pkg;

    typedef logic [`DPMB_DATA_W-1:0] dpmb_word_t;

    // decoded port control, all active high
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic box;
        logic en;
    } dpmb_ctl_t;

    typedef enum logic [1:0] {
        DPMB_MAIL_EMPTY = 2'h1,
        DPMB_MAIL_FULL  = 2'h2
    } dpmb_mail_st_t;

endpackage : dpmb_pkg

// File: tb/dpmb_fifo_model.sv
// far-side fifo output register model feeding the port-b mux
`timescale 1ns/10ps
module dpmb_fifo_model
(
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             read_in,
    output dpmb_pkg::dpmb_word_t  word_out
);
    // a fresh word is shifted in after every qualified fifo read
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            word_out <= 36'h0A5A5A5A5;
        else if (read_in)
            word_out <= word_out + 36'h000000001;
endmodule : dpmb_fifo_model

// File: tb/dpmb_mailbox_tb.sv
// self-checking bench for the dual-port mailbox bypass block
`timescale 1ns/10ps
module dpmb_mailbox_tb;
    // control nibble: chip_select_n, write_not_read, enable, box_select
    localparam logic [3:0] OP_IDLE = 4'h8;
    localparam logic [3:0] OP_AW   = 4'h7;
    localparam logic [3:0] OP_BR   = 4'h7;
    localparam logic [3:0] OP_AR   = 4'h3;
    localparam logic [3:0] OP_BW   = 4'h3;
    localparam logic [3:0] OP_FIFO = 4'h6;
    localparam logic [3:0] OP_AW_D = 4'h5;
    logic                  clk_in = 1'b0;
    logic                  rst_in = 1'b1;
    logic [3:0]            ctl [2] = '{OP_IDLE, OP_IDLE};
    dpmb_pkg::dpmb_word_t  dat [2] = '{36'h000000000, 36'h000000000};
    dpmb_pkg::dpmb_word_t  fifo_word;
    logic [35:0]           a_q, b_q;
    logic                  a_oe, b_oe, a_fw, b_fr, f_ab, f_ba;
    int                    n_errors = 0;
    int                    cmp_count = 0;
    always #50 clk_in = ~clk_in;
    dpmb_mailbox dut (.clk_in(clk_in), .rst_in(rst_in),
        .port_a_chip_select_n_in(ctl[0][3]), .port_a_write_not_read_in(ctl[0][2]),
        .port_a_enable_in(ctl[0][1]), .port_a_box_select_in(ctl[0][0]), .port_a_data_bus_in(dat[0]),
        .port_a_data_bus_out(a_q), .port_a_data_bus_oe_out(a_oe),
        .port_b_chip_select_n_in(ctl[1][3]), .port_b_write_not_read_in(ctl[1][2]),
        .port_b_enable_in(ctl[1][1]), .port_b_box_select_in(ctl[1][0]), .port_b_data_bus_in(dat[1]),
        .fifo_out_word_in(fifo_word), .port_b_data_bus_out(b_q), .port_b_data_bus_oe_out(b_oe),
        .port_a_fifo_write_out(a_fw), .port_b_fifo_read_out(b_fr),
        .a_to_b_mail_flag_n_out(f_ab), .b_to_a_mail_flag_n_out(f_ba));
    dpmb_fifo_model fifo (.clk_in(clk_in), .rst_in(rst_in), .read_in(b_fr), .word_out(fifo_word));
    // drive one port after an edge, hold it for n edges, stop at the falling edge
    task automatic drv(input int p, input logic [3:0] c, input logic [35:0] d, input int n);
        @(posedge clk_in);
        ctl[p] <= c;
        dat[p] <= d;
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask : drv
    task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        chk("flag_ab reset", 36'h1, f_ab);
        chk("flag_ba reset", 36'h1, f_ba);
        chk("oe_a reset", 36'h0, a_oe);
        chk("oe_b reset", 36'h0, b_oe);
        chk("fifo write strobe reset", 36'h0, a_fw);
        drv(0, OP_AW, 36'h123456789, 1);
        drv(0, OP_IDLE, 36'h0, 4);
        chk("flag_ab after write", 36'h0, f_ab);
        chk("flag_ba untouched", 36'h1, f_ba);
        drv(0, OP_AW, 36'hFEDCBA987, 1);
        drv(0, OP_IDLE, 36'h0, 4);
        drv(1, OP_BR, 36'h0, 3);
        chk("oe_b on read", 36'h1, b_oe);
        chk("b data blocked write", 36'h123456789, b_q);
        drv(1, OP_IDLE, 36'h0, 4);
        chk("flag_ab after read", 36'h1, f_ab);
        drv(1, OP_BR, 36'h0, 3);
        chk("b data reread", 36'h123456789, b_q);
        drv(1, OP_IDLE, 36'h0, 4);
        drv(0, OP_AW_D, 36'hFEDCBA987, 1);
        drv(0, OP_IDLE, 36'h0, 4);
        chk("flag_ab enable low", 36'h1, f_ab);
        drv(0, OP_AW, 36'hFEDCBA987, 1);
        drv(0, OP_IDLE, 36'h0, 4);
        drv(1, OP_FIFO, 36'h0, 3);
        chk("b data fifo path", fifo_word, b_q);
        chk("fifo read strobe", 36'h1, b_fr);
        drv(1, OP_IDLE, 36'h0, 4);
        chk("flag_ab fifo read", 36'h0, f_ab);
        drv(1, OP_BR, 36'h0, 3);
        chk("b data second mail", 36'hFEDCBA987, b_q);
        drv(1, OP_BW, 36'h0F0F0F0F0, 1);
        drv(1, OP_IDLE, 36'h0, 4);
        chk("flag_ba after write", 36'h0, f_ba);
        drv(0, OP_AR, 36'h0, 3);
        chk("oe_a on read", 36'h1, a_oe);
        chk("a data mail", 36'h0F0F0F0F0, a_q);
        drv(0, OP_IDLE, 36'h0, 4);
        chk("flag_ba after read", 36'h1, f_ba);
        chk("oe_a released", 36'h0, a_oe);
        drv(0, OP_FIFO, 36'h111111111, 2);
        chk("fifo write strobe", 36'h1, a_fw);
        drv(0, OP_IDLE, 36'h0, 4);
        chk("flag_ab fifo write", 36'h1, f_ab);
        chk("fifo write strobe idle", 36'h0, a_fw);
        chk("fifo read strobe idle", 36'h0, b_fr);
        finish_test();
    end
endmodule : dpmb_mailbox_tb
